/* hw/dofsb_cfg.svh */
`ifndef DOFSB_CFG_SVH
`define DOFSB_CFG_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define DOFSB_ADDR_FAULT   8'h00
`define DOFSB_ADDR_SUPPLY  8'h01

// ****************************************************************
// Field positions
// ****************************************************************
`define DOFSB_F0_DIS       0
`define DOFSB_F0_OC        2
`define DOFSB_F0_PBAD      4
`define DOFSB_F0_UV        6
`define DOFSB_F0_OT        7
`define DOFSB_F1_PUMP      0
`define DOFSB_F1_TONE      2
`define DOFSB_F1_TRIM      4
`define DOFSB_CTRL_EN1     3
`define DOFSB_CTRL_EN2     7

// ****************************************************************
// Reset values
// ****************************************************************
`define DOFSB_CTRL_RST     8'h00
`define DOFSB_BYTE_ZERO    8'h00

// ****************************************************************
// Timing: clock rate and overcurrent disable time
// ****************************************************************
`define DOFSB_CLK_MHZ      40
`define DOFSB_T_DIS_US     45000
`define DOFSB_OC_CYCLES    (`DOFSB_T_DIS_US * `DOFSB_CLK_MHZ)
`define DOFSB_OC_CNT_W     21

`endif

/* hw/dofsb_oc_if.sv */
`timescale 1ns/1ps

// Carries one output's overcurrent sense to its timer and the trip back
interface dofsb_oc_if;
  logic over;
  logic trip;

  modport ctrl  (output over, input trip);
  modport timer (input over, output trip);
endinterface

/* hw/dofsb_oc_timer.sv */
`timescale 1ns/1ps
`include "dofsb_cfg.svh"

// ****************************************************************
// Overcurrent persistence timer for one output
// ****************************************************************
module dofsb_oc_timer #(
  parameter int unsigned P_OC_CYCLES = `DOFSB_OC_CYCLES
) (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_sys_rst,
  // Sense and trip
  dofsb_oc_if.timer oc
);
  import dofsb_pkg::*;

  logic [`DOFSB_OC_CNT_W-1:0] cnt_q;
  logic [`DOFSB_OC_CNT_W-1:0] cnt_d;
  logic [`DOFSB_OC_CNT_W-1:0] lim;
  logic                       past_lim;

  assign lim      = `DOFSB_OC_CNT_W'(P_OC_CYCLES);
  assign past_lim = (cnt_q > lim);
  // Any break in the overload restarts the count; saturate once past
  assign cnt_d    = !oc.over ? '0 : (past_lim ? cnt_q : cnt_q + 1'b1);
  assign oc.trip  = oc.over && past_lim;

  // Count cycles of continuous overload
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

endmodule // dofsb_oc_timer

/* hw/dofsb_pkg.sv */
package dofsb_pkg;

  // Status and control bytes
  typedef logic [7:0] dofsb_byte_t;

  // One bit per regulated output
  typedef logic [1:0] dofsb_pair_t;

endpackage

/* hw/dofsb_status_bank.sv */
// How it works
// - Faults stay set until read and cleared
// - Undervoltage from main or internal supply low
// - Disabled set by any fault or enable off
// - Disabled clears only when faultless and enabled
// - Power-bad, pump-good, tone flags follow live
// - First status byte layout at address zero
// - Second status byte layout at address one
// - Only latched faults pull interrupt low
// - Overcurrent flag after sustained overload time
// - Overtemperature sets flag, disables both outputs
// - Undervoltage disables both outputs
// - Pump voltage low disables that output
// - Power-bad hysteresis: nine percent set, five clear
// - Tone flag uses transmit or receive threshold
// - Interrupt released on read, unlatch on ack
// - Enable ignored until fault read cleared
// - Control register zero at power-up
`timescale 1ns/1ps
`include "dofsb_cfg.svh"

module dofsb_status_bank #(
  parameter int unsigned P_OC_CYCLES = `DOFSB_OC_CYCLES
) (
  // Clock and reset (reset is the power-up undervoltage)
  input  wire logic               i_clk_sys,
  input  wire logic               i_sys_rst,
  // Control register write, already decoded from the serial port
  input  wire logic               i_ctrl_wr,
  input  wire dofsb_pkg::dofsb_byte_t i_ctrl_data,
  // Status read: address phase acked by us, data byte acked by master
  input  wire logic               i_rd_start,
  input  wire dofsb_pkg::dofsb_byte_t i_rd_addr,
  input  wire logic               i_master_ack,
  output logic                    o_rd_data_vld,
  output dofsb_pkg::dofsb_byte_t  o_rd_data,
  // Analog sense comparators
  input  wire logic               i_main_supply_low,
  input  wire logic               i_internal_supply_low,
  input  wire logic               i_overtemp,
  input  wire dofsb_pkg::dofsb_pair_t i_overcurrent,
  input  wire dofsb_pkg::dofsb_pair_t i_pump_good,
  input  wire dofsb_pkg::dofsb_pair_t i_out_beyond9,
  input  wire dofsb_pkg::dofsb_pair_t i_out_within5,
  input  wire dofsb_pkg::dofsb_pair_t i_tone_transmit_bit,
  input  wire dofsb_pkg::dofsb_pair_t i_tone_xmt_seen,
  input  wire dofsb_pkg::dofsb_pair_t i_tone_rcv_seen,
  input  wire logic               i_trim_lock,
  // Outputs to the power stage and the host
  output dofsb_pkg::dofsb_pair_t  o_output_on,
  output dofsb_pkg::dofsb_byte_t  o_ctrl,
  output logic                    o_irq_n
);
  import dofsb_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  dofsb_byte_t ctrl_q;
  logic        uv_q;
  logic        ot_q;
  dofsb_pair_t oc_q;
  dofsb_pair_t dis_q;
  dofsb_pair_t pbad_q;
  dofsb_pair_t tone_q;
  dofsb_pair_t pump_q;
  logic        trim_q;
  logic        irq_q;
  logic        rd_vld_q;
  dofsb_byte_t rd_data_q;

  // ****************************************************************
  // Decode of sense conditions and clear events
  // ****************************************************************
  logic        uv_cond;
  logic        uv_set;
  logic        ot_set;
  dofsb_pair_t oc_trip;
  dofsb_pair_t oc_set;
  dofsb_pair_t enable;
  dofsb_pair_t fault;
  dofsb_pair_t tone_now;
  logic        unlatch;
  logic        irq_set;
  dofsb_byte_t stat0;
  dofsb_byte_t stat1;
  dofsb_byte_t rd_mux;

  assign uv_cond = i_main_supply_low || i_internal_supply_low;
  // New latch events: a condition seen while its bit is still clear
  assign uv_set  = uv_cond && !uv_q;
  assign ot_set  = i_overtemp && !ot_q;
  assign oc_set  = oc_trip & ~oc_q;
  // Unlatching waits for the master's ack of the status byte
  assign unlatch = i_master_ack;
  assign irq_set = uv_set || ot_set || (|oc_set);

  assign enable  = {ctrl_q[`DOFSB_CTRL_EN2], ctrl_q[`DOFSB_CTRL_EN1]};
  // Latched faults block enable until a read clears them
  assign fault   = {2{uv_q | ot_q}} | oc_q | ~i_pump_good;

  // Threshold chosen per output by its transmit bit
  assign tone_now = (i_tone_transmit_bit & i_tone_xmt_seen)
                  | (~i_tone_transmit_bit & i_tone_rcv_seen);

  // ****************************************************************
  // Overcurrent timers, one per output
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_oc
      dofsb_oc_if oc_bus ();
      assign oc_bus.over = i_overcurrent[g];
      assign oc_trip[g]  = oc_bus.trip;
      dofsb_oc_timer #(
        .P_OC_CYCLES (P_OC_CYCLES)
      ) u_timer (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .oc        (oc_bus)
      );
    end
  endgenerate

  // ****************************************************************
  // Status byte assembly
  // ****************************************************************
  assign stat0 = {ot_q, uv_q, pbad_q, oc_q, dis_q};
  assign stat1 = {3'h0, trim_q, tone_q, pump_q};
  assign rd_mux = (i_rd_addr == `DOFSB_ADDR_FAULT)  ? stat0 :
                  (i_rd_addr == `DOFSB_ADDR_SUPPLY) ? stat1 : `DOFSB_BYTE_ZERO;

  // Control register; power-up clears every enable
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      ctrl_q <= `DOFSB_CTRL_RST;
    else if (i_ctrl_wr)
      ctrl_q <= i_ctrl_data;
  end

  // Latched faults: a read ack clears only a condition that has gone,
  // and a condition still present wins over the clear
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      uv_q <= 1'b1; // Power-up itself is reported as undervoltage
      ot_q <= 1'b0;
      oc_q <= 2'h0;
    end
    else
    begin
      uv_q <= uv_cond || (uv_q && !unlatch);
      ot_q <= i_overtemp || (ot_q && !unlatch);
      oc_q <= oc_trip | (oc_q & {2{!unlatch}});
    end
  end

  // Disabled flags: set by fault or enable off, cleared otherwise
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      dis_q <= 2'h3;
    else
      dis_q <= fault | ~enable | (dis_q & (fault | ~enable));
  end

  // Live flags; power-bad holds between the two thresholds
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      pbad_q <= 2'h0;
      pump_q <= 2'h0;
      tone_q <= 2'h0;
    end
    else
    begin
      pbad_q <= ~dis_q & (i_out_beyond9 | (pbad_q & ~i_out_within5));
      pump_q <= i_pump_good;
      tone_q <= tone_now;
    end
  end

  // Trim lock is set-only; nothing but power-up clears it
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      trim_q <= 1'b0;
    else if (i_trim_lock)
      trim_q <= 1'b1;
  end

  // Interrupt: set by a new latch, released when a read starts
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
      irq_q <= 1'b1; // Pending after power-up to report undervoltage
    else
      irq_q <= irq_set || (irq_q && !i_rd_start);
  end

  // Read data captured at the read start so the byte stays stable
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      rd_vld_q  <= 1'b0;
      rd_data_q <= `DOFSB_BYTE_ZERO;
    end
    else
    begin
      rd_vld_q <= i_rd_start;
      if (i_rd_start)
        rd_data_q <= rd_mux;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_output_on   = ~dis_q;
  assign o_ctrl        = ctrl_q;
  assign o_irq_n       = ~irq_q;
  assign o_rd_data     = rd_data_q;
  assign o_rd_data_vld = rd_vld_q;

endmodule // dofsb_status_bank

/* sim/dofsb_checker.sv */
`timescale 1ns/1ps
// ****
// Port checker for the status bank
// ****
module dofsb_checker (
  // Clock, reset and control write
  input logic                   i_clk_sys,
  input logic                   i_sys_rst,
  input logic                   i_ctrl_wr,
  input dofsb_pkg::dofsb_byte_t i_ctrl_data,
  // Read port
  input logic                   i_rd_start,
  input dofsb_pkg::dofsb_byte_t i_rd_addr,
  input logic                   o_rd_data_vld,
  input dofsb_pkg::dofsb_byte_t o_rd_data,
  // Sense inputs
  input logic                   i_main_supply_low,
  input logic                   i_internal_supply_low,
  input logic                   i_overtemp,
  input dofsb_pkg::dofsb_pair_t i_overcurrent,
  input dofsb_pkg::dofsb_pair_t i_pump_good,
  // Outputs
  input dofsb_pkg::dofsb_pair_t o_output_on,
  input dofsb_pkg::dofsb_byte_t o_ctrl,
  input logic                   o_irq_n
);
  import dofsb_pkg::*;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // Cycles since a latching source was seen; bounds the interrupt delay
  logic [2:0] age_q;
  wire        hard = i_main_supply_low | i_internal_supply_low | i_overtemp;
  always_ff @(posedge i_clk_sys)
    age_q <= (hard | (|i_overcurrent)) ? 3'h0 : (i_sys_rst | &age_q) ? 3'h7 : age_q + 3'h1;

  a_rd_answer: assert property (i_rd_start |=> o_rd_data_vld)
    else $error("read not answered");
  a_rd_stands: assert property (!i_rd_start |=> $stable(o_rd_data))
    else $error("read data moved");
  a_unused_zero: assert property (i_rd_start && i_rd_addr == 8'h01 |=> o_rd_data[7:5] == 3'h0)
    else $error("unused bits set");
  a_irq_cause: assert property ($fell(o_irq_n) |-> age_q < 3'h5)
    else $error("interrupt without latching fault");
  a_irq_release: assert property ($rose(o_irq_n) |-> $past(i_rd_start))
    else $error("interrupt released without read");
  a_fault_both_off: assert property (hard |-> ##[1:4] o_output_on == 2'h0)
    else $error("outputs not disabled");
  a_pump_off: assert property (!i_pump_good[1] |-> ##[1:4] !o_output_on[1])
    else $error("pump fault left output on");
  a_en_off: assert property (!o_ctrl[3] |-> ##[1:4] !o_output_on[0])
    else $error("disabled output still on");
  a_ctrl_load: assert property (i_ctrl_wr |=> o_ctrl == $past(i_ctrl_data))
    else $error("control byte not stored");
  c_ot_read: cover property (o_rd_data_vld && o_rd_data == 8'h83);
  c_irq_low: cover property ($fell(o_irq_n));
  c_out_on: cover property ($rose(o_output_on[0]));
endmodule // dofsb_checker

/* sim/dofsb_master_model.sv */
`timescale 1ns/1ps
// ****
// Host master issuing status reads
// ****
module dofsb_master_model (
  // Clock
  input  logic                   i_clk_sys,
  // Read strobes toward the bank
  output logic                   o_rd_start   = 1'b0,
  output dofsb_pkg::dofsb_byte_t o_rd_addr    = 8'hff,
  output logic                   o_master_ack = 1'b0
);
  // One byte; ack is optional so a fault can be left latched on purpose
  task automatic rd(input dofsb_pkg::dofsb_byte_t a, input logic ack);
    @(negedge i_clk_sys);
    o_rd_start = 1'b1;
    o_rd_addr  = a;
    @(negedge i_clk_sys);
    o_rd_start = 1'b0;
    o_rd_addr  = ~a;  // Released address shows a changed pattern
    o_master_ack = ack;
    @(negedge i_clk_sys);
    o_master_ack = 1'b0;
  endtask
endmodule // dofsb_master_model

/* sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import dofsb_pkg::*;
  // ****
  // Stimulus, design and master
  // ****
  logic        i_clk_sys = 1'b0, i_sys_rst = 1'b1, i_ctrl_wr = 1'b0, i_trim_lock = 1'b0;
  logic        i_main_supply_low = 1'b0, i_internal_supply_low = 1'b0, i_overtemp = 1'b0;
  logic        i_rd_start, i_master_ack, o_rd_data_vld, o_irq_n;
  dofsb_byte_t i_ctrl_data = 8'h00, i_rd_addr, o_rd_data, o_ctrl, exp_q[$];
  dofsb_pair_t i_overcurrent = 2'h0, i_pump_good = 2'h3, i_out_beyond9 = 2'h0;
  dofsb_pair_t i_out_within5 = 2'h3, i_tone_transmit_bit, i_tone_xmt_seen, i_tone_rcv_seen;
  dofsb_pair_t o_output_on;
  int          n_fail = 0, compares = 0;
  always #12.5 i_clk_sys = ~i_clk_sys;
  // Short trip count keeps the overcurrent cases quick
  dofsb_status_bank #(.P_OC_CYCLES(20)) dut_u (
    .i_clk_sys             (i_clk_sys),
    .i_sys_rst             (i_sys_rst),
    .i_ctrl_wr             (i_ctrl_wr),
    .i_ctrl_data           (i_ctrl_data),
    .i_rd_start            (i_rd_start),
    .i_rd_addr             (i_rd_addr),
    .i_master_ack          (i_master_ack),
    .o_rd_data_vld         (o_rd_data_vld),
    .o_rd_data             (o_rd_data),
    .i_main_supply_low     (i_main_supply_low),
    .i_internal_supply_low (i_internal_supply_low),
    .i_overtemp            (i_overtemp),
    .i_overcurrent         (i_overcurrent),
    .i_pump_good           (i_pump_good),
    .i_out_beyond9         (i_out_beyond9),
    .i_out_within5         (i_out_within5),
    .i_tone_transmit_bit   (i_tone_transmit_bit),
    .i_tone_xmt_seen       (i_tone_xmt_seen),
    .i_tone_rcv_seen       (i_tone_rcv_seen),
    .i_trim_lock           (i_trim_lock),
    .o_output_on           (o_output_on),
    .o_ctrl                (o_ctrl),
    .o_irq_n               (o_irq_n)
  );
  dofsb_master_model m_u (
    .i_clk_sys    (i_clk_sys),
    .o_rd_start   (i_rd_start),
    .o_rd_addr    (i_rd_addr),
    .o_master_ack (i_master_ack)
  );

  task automatic chk(input dofsb_byte_t g, input dofsb_byte_t e);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  // Expectation is queued before the master starts the read
  task automatic rd(input dofsb_byte_t a, input dofsb_byte_t e, input logic ack = 1'b0);
    exp_q.push_back(e);
    m_u.rd(a, ack);
  endtask
  task automatic wr(input dofsb_byte_t d);
    tick(1);
    {i_ctrl_wr, i_ctrl_data} = {1'b1, d};
    tick(1);
    i_ctrl_wr = 1'b0;
  endtask
  function automatic dofsb_byte_t exp1(input logic t);
    return {3'h0, t, (i_tone_transmit_bit & i_tone_xmt_seen) |
            (~i_tone_transmit_bit & i_tone_rcv_seen), i_pump_good};
  endfunction
  task automatic conclude;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Each answer is matched with the oldest pending expectation
  always @(posedge i_clk_sys)
  begin
    #1;
    if (o_rd_data_vld === 1'b1)
      chk(o_rd_data, exp_q.size() > 0 ? exp_q.pop_front() : ~o_rd_data);
  end
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge i_clk_sys);
    n_fail++;
    conclude;
  end

  initial
  begin
    void'($urandom(72));
    {i_tone_transmit_bit, i_tone_xmt_seen, i_tone_rcv_seen} = 6'h00;
    tick(8);
    i_sys_rst = 1'b0;
    chk({7'h0, o_irq_n}, 8'h00);
    rd(8'h00, 8'h43, 1'b1);
    rd(8'h00, 8'h03);
    chk({7'h0, o_irq_n}, 8'h01);
    chk(o_ctrl, 8'h00);
    wr(8'h88);
    tick(4);
    chk({6'h0, o_output_on}, 8'h03);
    rd(8'h00, 8'h00);
    rd(8'h05, 8'h00);
    repeat (4)
    begin
      {i_tone_transmit_bit, i_tone_xmt_seen, i_tone_rcv_seen} = 6'($urandom);
      tick(2);
      rd(8'h01, exp1(1'b0));
    end
    i_trim_lock = 1'b1;
    tick(1);
    i_trim_lock = 1'b0;
    tick(2);
    rd(8'h01, exp1(1'b1));
    i_overtemp = 1'b1;
    tick(4);
    chk({7'h0, o_irq_n}, 8'h00);
    rd(8'h00, 8'h83, 1'b1);
    i_overtemp = 1'b0;
    rd(8'h00, 8'h83, 1'b1);
    tick(3);
    rd(8'h00, 8'h00);
    // Exactly the limit must not trip; a few more cycles must
    i_overcurrent = 2'h1;
    tick(20);
    i_overcurrent = 2'h0;
    tick(3);
    rd(8'h00, 8'h00);
    i_overcurrent = 2'h1;
    tick(24);
    i_overcurrent = 2'h0;
    tick(3);
    rd(8'h00, 8'h05, 1'b1);
    i_pump_good = 2'h1;
    tick(4);
    rd(8'h00, 8'h02);
    rd(8'h01, exp1(1'b1));
    i_pump_good = 2'h3;
    {i_out_beyond9, i_out_within5} = 4'h6;
    tick(4);
    rd(8'h00, 8'h10);
    i_out_beyond9 = 2'h0;
    tick(3);
    rd(8'h00, 8'h10);
    i_out_within5 = 2'h3;
    tick(3);
    rd(8'h00, 8'h00);
    i_internal_supply_low = 1'b1;
    tick(4);
    rd(8'h00, 8'h43, 1'b1);
    i_internal_supply_low = 1'b0;
    i_main_supply_low = 1'b1;
    rd(8'h00, 8'h43, 1'b1);
    i_main_supply_low = 1'b0;
    rd(8'h00, 8'h43, 1'b1);
    wr(8'h08);
    tick(4);
    rd(8'h00, 8'h02);
    chk({6'h0, o_output_on}, 8'h01);
    chk(o_ctrl, 8'h08);
    // Power-up again in mid-run: enables and trim must clear, undervoltage, disabled and interrupt must come back set
    i_sys_rst = 1'b1;
    tick(2);
    i_sys_rst = 1'b0;
    chk(o_ctrl, 8'h00);
    chk({6'h0, o_output_on}, 8'h00);
    chk({7'h0, o_irq_n}, 8'h00);
    rd(8'h00, 8'h43);
    rd(8'h01, exp1(1'b0));
    tick(4);
    chk(8'(exp_q.size()), 8'h00);
    conclude;
  end
endmodule // tb_top

bind dofsb_status_bank dofsb_checker chk_u (
  .i_clk_sys             (i_clk_sys),
  .i_sys_rst             (i_sys_rst),
  .i_ctrl_wr             (i_ctrl_wr),
  .i_ctrl_data           (i_ctrl_data),
  .i_rd_start            (i_rd_start),
  .i_rd_addr             (i_rd_addr),
  .o_rd_data_vld         (o_rd_data_vld),
  .o_rd_data             (o_rd_data),
  .i_main_supply_low     (i_main_supply_low),
  .i_internal_supply_low (i_internal_supply_low),
  .i_overtemp            (i_overtemp),
  .i_overcurrent         (i_overcurrent),
  .i_pump_good           (i_pump_good),
  .o_output_on           (o_output_on),
  .o_ctrl                (o_ctrl),
  .o_irq_n               (o_irq_n)
);
